// ===== inc/lps_pkg.sv
// constants, codes and states of the light pulse sequencer
// assumes a 250 MHz clock and an apb master with 32-bit data
package lps_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int MS_US = 1000;
  localparam logic [7:0] US_LAST = 8'(US_NS / CLK_PERIOD_NS - 1);
  localparam logic [9:0] MS_LAST = 10'(MS_US - 1);
  localparam int ON_SLACK_NS = 5000;
  localparam logic [31:0] ON_SLACK_US = 32'(ON_SLACK_NS / US_NS);
  // scaling
  localparam logic [8:0] ANALOG_FS_MA = 9'd400;
  localparam logic [15:0] SAMPLE_COUNT = 16'd1000;
  localparam logic [14:0] SAMPLE_ONE = 15'h4000;
  localparam logic [31:0] SAMPLE_STEP = 32'd1000;
  localparam logic [10:0] DUTY_FULL = 11'h400;
  localparam logic [6:0] PCT_FULL = 7'h64;
  // register byte addresses
  localparam logic [15:0] CTRL_ADDR = 16'h0000;
  localparam logic [15:0] STATUS_ADDR = 16'h0004;
  localparam logic [15:0] CURRENT_ADDR = 16'h0008;
  localparam logic [15:0] MAXCUR_ADDR = 16'h000c;
  localparam logic [15:0] SDELAY_ADDR = 16'h0010;
  localparam logic [15:0] PERIOD_ADDR = 16'h0014;
  localparam logic [15:0] ONTIME_ADDR = 16'h0018;
  localparam logic [15:0] RISE_ADDR = 16'h001c;
  localparam logic [15:0] PLAT_ADDR = 16'h0020;
  localparam logic [15:0] FALL_ADDR = 16'h0024;
  localparam logic [15:0] PULSES_ADDR = 16'h0028;
  localparam logic [15:0] SEQS_ADDR = 16'h002c;
  localparam logic [15:0] GAP_ADDR = 16'h0030;
  localparam logic [15:0] ECOUNT_ADDR = 16'h0034;
  localparam logic [15:0] PROGRESS_ADDR = 16'h0038;
  localparam logic [15:0] ELAPSED_ADDR = 16'h003c;
  localparam logic [15:0] TOTAL_ADDR = 16'h0040;
  localparam logic [15:0] DUTY_ADDR = 16'h0044;
  localparam logic [15:0] ENTRY_BASE = 16'h0100;
  localparam logic [15:0] ENTRY_END = 16'h0200;
  localparam logic [15:0] SAMPLE_BASE = 16'h1000;
  localparam logic [15:0] SAMPLE_END = 16'h2000;
  // ctrl fields
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_CLEAR = 2;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_SMOOTH = 8;
  localparam int CTRL_DUTY = 9;
  // entry fields (word index inside an entry)
  localparam logic [2:0] F_TYPE = 3'h0;
  localparam logic [2:0] F_PEAK = 3'h1;
  localparam logic [2:0] F_PERIOD = 3'h2;
  localparam logic [2:0] F_ON = 3'h3;
  localparam logic [2:0] F_PULSES = 3'h4;
  localparam logic [2:0] F_SEQS = 3'h5;
  localparam logic [2:0] F_GAP = 3'h6;
  // modes and entry kinds
  localparam logic [2:0] M_CONST = 3'h0;
  localparam logic [2:0] M_EXTDIG = 3'h1;
  localparam logic [2:0] M_EXTANA = 3'h2;
  localparam logic [2:0] M_SQUARE = 3'h3;
  localparam logic [2:0] M_COMPLEX = 3'h4;
  localparam logic [2:0] M_CUSTOM = 3'h5;
  localparam logic [1:0] E_SQUARE = 2'h0;
  localparam logic [1:0] E_TRIANGLE = 2'h1;
  localparam logic [1:0] E_RAMP = 2'h2;
  localparam logic [1:0] E_DELAY = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DELAY, ST_LOAD, ST_PULSE, ST_GAP
  } lps_state_type;
  typedef enum logic [1:0] {
    AK_NONE, AK_REG, AK_ENTRY, AK_SAMPLE
  } lps_kind_type;
endpackage

// ===== logic/lps_sequencer.sv
// light pulse sequencer: one channel's current engine, apb slave
// assumes pins synchronous to CLK_I; drive level is in mA
//
// Added by the designer: the register addresses and the APB register port.
module lps_sequencer
  import lps_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic EXT_DIGITAL_I,
  input wire logic [11:0] EXT_ANALOG_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [11:0] DRIVE_LEVEL_O,
  output logic LIGHT_ON_O,
  output logic RUNNING_O,
  output logic CONFIG_INVALID_O,
  output logic EXTERNAL_DIGITAL_MODE_INDICATOR_O,
  output logic CONSTANT_CURRENT_MODE_INDICATOR_O
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] mode;
    logic smooth;
    logic duty_sel;
    logic [11:0] cur;
    logic [11:0] maxcur;
    logic [31:0] sdelay;
    logic [31:0] period;
    logic [31:0] ontime;
    logic [10:0] duty;
    logic [31:0] rise;
    logic [31:0] plat;
    logic [31:0] fall;
    logic [15:0] pulses;
    logic [15:0] seqs;
    logic [31:0] gap;
    logic [3:0] ecount;
    logic [31:0] total;
    logic [15:0] scount;
    lps_state_type st;
    logic run;
    logic invalid;
    logic [7:0] us_div;
    logic [9:0] ms_div;
    logic [31:0] t;
    logic [31:0] dly;
    logic [15:0] pc;
    logic [15:0] sc;
    logic [2:0] eidx;
    logic [11:0] pk;
    logic [31:0] per;
    logic [31:0] ri;
    logic [31:0] pl;
    logic [31:0] fa;
    logic [31:0] gp;
    logic [15:0] np;
    logic [15:0] ns;
    logic [32:0] acc;
    logic [11:0] lvl;
    logic [9:0] sidx;
    logic [31:0] sacc;
    logic [31:0] elapsed;
    logic [6:0] pct;
    logic [31:0] pacc;
    logic [11:0] drive;
    logic light;
    logic ind_dig;
    logic ind_const;
  } lps_regs_type;

  lps_regs_type q;
  lps_regs_type next_q;
  logic [31:0] entry_mem [0:63];
  logic [14:0] sample_mem [0:1023];

  function automatic lps_kind_type addr_kind(input logic [15:0] a);
    if (a[1:0] != 2'h0) begin
      addr_kind = AK_NONE;
    end else if (a <= DUTY_ADDR) begin
      addr_kind = AK_REG;
    end else if (a >= ENTRY_BASE && a < ENTRY_END) begin
      addr_kind = AK_ENTRY;
    end else if (a >= SAMPLE_BASE && a < SAMPLE_END) begin
      addr_kind = AK_SAMPLE;
    end else begin
      addr_kind = AK_NONE;
    end
  endfunction

  // square on-time as configured
  function automatic logic [31:0] square_on(input lps_regs_type r);
    logic [42:0] prod;
    prod = r.period * r.duty;
    if (r.smooth) begin
      square_on = r.rise + r.plat + r.fall;
    end else if (r.duty_sel) begin
      square_on = prod[41:10];
    end else begin
      square_on = r.ontime;
    end
  endfunction

  lps_kind_type kind;
  logic access;
  logic wr;
  logic us_tick;
  logic ms_tick;
  logic seq_mode;
  logic [31:0] on_eff;
  logic [31:0] ent [0:7];
  logic [14:0] samp;
  logic [20:0] ana;
  logic [26:0] cust;
  logic [11:0] peak_live;
  logic [11:0] raw;
  logic [9:0] widx;

  assign kind = addr_kind(PADDR_I);
  assign access = PSEL_I && PENABLE_I && !q.pready;
  // a write lands only on the edge where the master sees pready
  assign wr = PSEL_I && PENABLE_I && PWRITE_I && q.pready && !q.pslverr;
  assign us_tick = q.us_div == US_LAST;
  assign ms_tick = us_tick && q.ms_div == MS_LAST;
  assign seq_mode = q.mode == M_SQUARE || q.mode == M_COMPLEX ||
                    q.mode == M_CUSTOM;
  assign on_eff = square_on(q);
  assign widx = PADDR_I[11:2];
  assign ana = EXT_ANALOG_I * ANALOG_FS_MA;
  assign samp = (16'(q.sidx) < q.scount) ? sample_mem[q.sidx]
                                         : 15'h0000;
  assign peak_live = (q.mode == M_COMPLEX) ? q.pk : q.cur;
  assign cust = samp * peak_live;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ent
      assign ent[g] = entry_mem[{q.eidx, 3'(g)}];
    end
  endgenerate

  // tables sit outside the state struct; writes follow the bus rules
  always_ff @(posedge CLK_I) begin
    if (wr && kind == AK_ENTRY && !q.run) begin
      entry_mem[PADDR_I[7:2]] <= PWDATA_I;
    end
    if (wr && kind == AK_SAMPLE && !q.run &&
        16'(widx) < SAMPLE_COUNT) begin
      if (PWDATA_I[15]) begin
        sample_mem[widx] <= 15'h0000;
      end else if (PWDATA_I[14:0] > SAMPLE_ONE) begin
        sample_mem[widx] <= SAMPLE_ONE;
      end else begin
        sample_mem[widx] <= PWDATA_I[14:0];
      end
    end
  end

  always_comb begin
    next_q = q;
    raw = 12'h000;
    // bus answer: one wait state, then pready
    next_q.pready = access;
    // error flag only stands beside the ready pulse
    next_q.pslverr = 1'b0;
    if (access) begin
      next_q.pslverr = kind == AK_NONE ||
        (PWRITE_I && q.run && !(kind == AK_REG &&
        (PADDR_I == CTRL_ADDR || PADDR_I == CURRENT_ADDR)));
      next_q.prdata = 32'h0000_0000;
      if (!PWRITE_I && kind == AK_ENTRY) begin
        next_q.prdata = entry_mem[PADDR_I[7:2]];
      end else if (!PWRITE_I && kind == AK_SAMPLE) begin
        next_q.prdata = {17'h00000, sample_mem[widx]};
      end else if (!PWRITE_I) begin
        if (PADDR_I == CTRL_ADDR) begin
          next_q.prdata = {22'h0, q.duty_sel, q.smooth, 1'b0,
                           q.mode, 4'h0};
        end else if (PADDR_I == STATUS_ADDR) begin
          next_q.prdata = {25'h0, q.st, 2'h0, q.invalid,
                           q.run};
        end else if (PADDR_I == CURRENT_ADDR) begin
          next_q.prdata = {20'h0, q.cur};
        end else if (PADDR_I == MAXCUR_ADDR) begin
          next_q.prdata = {20'h0, q.maxcur};
        end else if (PADDR_I == SDELAY_ADDR) begin
          next_q.prdata = q.sdelay;
        end else if (PADDR_I == PERIOD_ADDR) begin
          next_q.prdata = q.period;
        end else if (PADDR_I == ONTIME_ADDR) begin
          next_q.prdata = on_eff;
        end else if (PADDR_I == RISE_ADDR) begin
          next_q.prdata = q.rise;
        end else if (PADDR_I == PLAT_ADDR) begin
          next_q.prdata = q.plat;
        end else if (PADDR_I == FALL_ADDR) begin
          next_q.prdata = q.fall;
        end else if (PADDR_I == PULSES_ADDR) begin
          next_q.prdata = {16'h0, q.pulses};
        end else if (PADDR_I == SEQS_ADDR) begin
          next_q.prdata = {16'h0, q.seqs};
        end else if (PADDR_I == GAP_ADDR) begin
          next_q.prdata = q.gap;
        end else if (PADDR_I == ECOUNT_ADDR) begin
          next_q.prdata = {28'h0, q.ecount};
        end else if (PADDR_I == PROGRESS_ADDR) begin
          next_q.prdata = {25'h0, q.pct};
        end else if (PADDR_I == ELAPSED_ADDR) begin
          next_q.prdata = q.elapsed;
        end else if (PADDR_I == TOTAL_ADDR) begin
          next_q.prdata = q.total;
        end else begin
          next_q.prdata = {21'h0, q.duty};
        end
      end
    end
    // validity of square timing, also guards start
    next_q.invalid = q.mode == M_SQUARE &&
      ((on_eff > q.period + ON_SLACK_US) ||
       (q.duty_sel && !q.smooth && q.duty >= DUTY_FULL));
    // register writes
    if (wr && kind == AK_REG) begin
      if (PADDR_I == CTRL_ADDR) begin
        if (!q.run) begin
          next_q.mode = PWDATA_I[CTRL_MODE_LO +: 3];
          next_q.smooth = PWDATA_I[CTRL_SMOOTH];
          next_q.duty_sel = PWDATA_I[CTRL_DUTY];
          if (PWDATA_I[CTRL_CLEAR]) begin
            next_q.scount = 16'h0000;
          end
        end
      end else if (PADDR_I == CURRENT_ADDR) begin
        next_q.cur = PWDATA_I[11:0];
      end else if (PADDR_I == MAXCUR_ADDR) begin
        next_q.maxcur = PWDATA_I[11:0];
      end else if (PADDR_I == SDELAY_ADDR) begin
        next_q.sdelay = PWDATA_I;
      end else if (PADDR_I == PERIOD_ADDR) begin
        next_q.period = PWDATA_I;
      end else if (PADDR_I == ONTIME_ADDR) begin
        next_q.ontime = PWDATA_I;
      end else if (PADDR_I == RISE_ADDR) begin
        next_q.rise = PWDATA_I;
      end else if (PADDR_I == PLAT_ADDR) begin
        next_q.plat = PWDATA_I;
      end else if (PADDR_I == FALL_ADDR) begin
        next_q.fall = PWDATA_I;
      end else if (PADDR_I == PULSES_ADDR) begin
        next_q.pulses = PWDATA_I[15:0];
      end else if (PADDR_I == SEQS_ADDR) begin
        next_q.seqs = PWDATA_I[15:0];
      end else if (PADDR_I == GAP_ADDR) begin
        next_q.gap = PWDATA_I;
      end else if (PADDR_I == ECOUNT_ADDR) begin
        next_q.ecount = PWDATA_I[3:0];
      end else if (PADDR_I == TOTAL_ADDR) begin
        next_q.total = PWDATA_I;
      end else if (PADDR_I == DUTY_ADDR) begin
        next_q.duty = PWDATA_I[10:0];
      end
    end
    if (wr && kind == AK_SAMPLE && !q.run &&
        16'(widx) < SAMPLE_COUNT && 16'(widx) >= q.scount) begin
      next_q.scount = 16'(widx) + 16'h0001;
    end
    // time base
    next_q.us_div = us_tick ? 8'h00 : q.us_div + 8'h01;
    if (us_tick) begin
      next_q.ms_div = ms_tick ? 10'h000 : q.ms_div + 10'h001;
    end
    // sequence engine
    case (q.st)
      ST_DELAY: begin
        if (q.dly >= q.sdelay) begin
          next_q.st = ST_LOAD;
        end else if (ms_tick) begin
          next_q.dly = q.dly + 32'h1;
        end
      end
      ST_LOAD: begin
        next_q.t = 32'h0;
        next_q.pc = 16'h0;
        next_q.sc = 16'h0;
        next_q.acc = 33'h0;
        next_q.lvl = 12'h000;
        next_q.sidx = 10'h000;
        next_q.sacc = 32'h0;
        next_q.st = ST_PULSE;
        if (q.mode == M_COMPLEX) begin
          next_q.pk = ent[F_PEAK][11:0];
          next_q.per = ent[F_PERIOD];
          next_q.gp = ent[F_GAP];
          next_q.np = (ent[F_PULSES][15:0] == 16'h0) ? 16'h1
                      : ent[F_PULSES][15:0];
          next_q.ns = (ent[F_SEQS][15:0] == 16'h0) ? 16'h1
                      : ent[F_SEQS][15:0];
          next_q.ri = 32'h0;
          next_q.pl = ent[F_ON];
          next_q.fa = 32'h0;
          if (ent[F_TYPE][1:0] == E_TRIANGLE) begin
            next_q.ri = ent[F_ON] >> 1;
            next_q.pl = 32'h0;
            next_q.fa = ent[F_ON] - (ent[F_ON] >> 1);
          end else if (ent[F_TYPE][1:0] == E_RAMP) begin
            next_q.ri = ent[F_ON];
            next_q.pl = 32'h0;
          end else if (ent[F_TYPE][1:0] == E_DELAY) begin
            next_q.pk = 12'h000;
          end
        end else if (q.mode == M_CUSTOM) begin
          next_q.per = q.period;
          next_q.np = 16'h1;
          next_q.ns = (q.seqs == 16'h0) ? 16'h1 : q.seqs;
          next_q.gp = q.gap;
        end else begin
          next_q.per = q.period;
          next_q.np = q.pulses;
          next_q.ns = q.seqs;
          next_q.gp = q.gap;
          next_q.ri = q.smooth ? q.rise : 32'h0;
          next_q.pl = q.smooth ? q.plat : on_eff;
          next_q.fa = q.smooth ? q.fall : 32'h0;
        end
      end
      ST_PULSE: begin
        if (q.mode == M_CUSTOM) begin
          // spread 1000 samples evenly over the period
          if (us_tick) begin
            next_q.sacc = q.sacc + SAMPLE_STEP;
          end else if (q.sacc >= q.per && q.sidx != 10'h3e7) begin
            next_q.sacc = q.sacc - q.per;
            next_q.sidx = q.sidx + 10'h001;
          end
        end else if (q.t < q.ri) begin
          // one step per clock keeps ramps exact without a divider
          if (us_tick) begin
            next_q.acc = q.acc + 33'(peak_live);
          end else if (q.acc >= 33'(q.ri) && q.lvl < peak_live) begin
            next_q.acc = q.acc - 33'(q.ri);
            next_q.lvl = q.lvl + 12'h001;
          end
        end else if (q.t < q.ri + q.pl) begin
          next_q.lvl = peak_live;
          next_q.acc = 33'h0;
        end else if (q.t < q.ri + q.pl + q.fa) begin
          if (us_tick) begin
            next_q.acc = q.acc + 33'(peak_live);
          end else if (q.acc >= 33'(q.fa) && q.lvl != 12'h000) begin
            next_q.acc = q.acc - 33'(q.fa);
            next_q.lvl = q.lvl - 12'h001;
          end
        end else begin
          next_q.lvl = 12'h000;
        end
        if (us_tick) begin
          next_q.t = q.t + 32'h1;
          if (q.t + 32'h1 >= q.per) begin
            next_q.t = 32'h0;
            next_q.acc = 33'h0;
            next_q.lvl = 12'h000;
            next_q.sidx = 10'h000;
            next_q.sacc = 32'h0;
            next_q.pc = q.pc + 16'h1;
            if (q.np != 16'h0 && q.pc + 16'h1 >= q.np) begin
              next_q.pc = 16'h0;
              next_q.sc = q.sc + 16'h1;
              if (q.ns != 16'h0 && q.sc + 16'h1 >= q.ns) begin
                if (q.mode == M_COMPLEX &&
                    4'(q.eidx) + 4'h1 < q.ecount) begin
                  next_q.eidx = q.eidx + 3'h1;
                  next_q.st = ST_LOAD;
                end else begin
                  next_q.run = 1'b0;
                  next_q.st = ST_IDLE;
                end
              end else begin
                next_q.dly = 32'h0;
                next_q.st = ST_GAP;
              end
            end
          end
        end
      end
      ST_GAP: begin
        if (q.dly >= q.gp) begin
          next_q.st = ST_PULSE;
        end else if (ms_tick) begin
          next_q.dly = q.dly + 32'h1;
        end
      end
      default: begin
        next_q.st = ST_IDLE;
      end
    endcase
    // progress, percent tracked against the host's total in ms
    if (q.run && seq_mode) begin
      if (ms_tick) begin
        next_q.elapsed = q.elapsed + 32'h1;
        next_q.pacc = q.pacc + 32'(PCT_FULL);
      end else if (q.total != 32'h0 && q.pacc >= q.total &&
                   q.pct < PCT_FULL) begin
        next_q.pacc = q.pacc - q.total;
        next_q.pct = q.pct + 7'h01;
      end
    end
    // start and stop commands
    if (wr && kind == AK_REG && PADDR_I == CTRL_ADDR) begin
      if (PWDATA_I[CTRL_STOP]) begin
        next_q.run = 1'b0;
        next_q.st = ST_IDLE;
      end else if (PWDATA_I[CTRL_START] && !q.run && !q.invalid) begin
        next_q.run = 1'b1;
        next_q.elapsed = 32'h0;
        next_q.pct = 7'h00;
        next_q.pacc = 32'h0;
        next_q.eidx = 3'h0;
        next_q.dly = 32'h0;
        next_q.st = seq_mode ? ST_DELAY : ST_IDLE;
      end
    end
    // output current
    if (q.run) begin
      if (q.mode == M_CONST) begin
        raw = q.cur;
      end else if (q.mode == M_EXTDIG) begin
        raw = EXT_DIGITAL_I ? q.cur : 12'h000;
      end else if (q.mode == M_EXTANA) begin
        raw = {3'h0, ana[20:12]};
      end else if (q.st == ST_PULSE && q.mode == M_CUSTOM) begin
        raw = cust[25:14];
      end else if (q.st == ST_PULSE) begin
        raw = q.lvl;
      end
    end
    // the source's own limit clips every mode
    next_q.drive = (raw > q.maxcur) ? q.maxcur : raw;
    next_q.light = next_q.drive != 12'h000;
    next_q.ind_dig = next_q.mode == M_EXTDIG;
    next_q.ind_const = next_q.mode == M_CONST;
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ind_const <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign PRDATA_O = q.prdata;
  assign PREADY_O = q.pready;
  assign PSLVERR_O = q.pslverr;
  assign DRIVE_LEVEL_O = q.drive;
  assign LIGHT_ON_O = q.light;
  assign RUNNING_O = q.run;
  assign CONFIG_INVALID_O = q.invalid;
  assign EXTERNAL_DIGITAL_MODE_INDICATOR_O = q.ind_dig;
  assign CONSTANT_CURRENT_MODE_INDICATOR_O = q.ind_const;

endmodule // lps_sequencer

// ===== test/lps_monitor.sv
// checker for the sequencer's apb and drive ports
// assumes one clock and a synchronous active-high reset
module lps_monitor
  import lps_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic EXT_DIGITAL_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [11:0] DRIVE_LEVEL_O,
  input wire logic LIGHT_ON_O,
  input wire logic RUNNING_O,
  input wire logic CONFIG_INVALID_O,
  input wire logic EXTERNAL_DIGITAL_MODE_INDICATOR_O,
  input wire logic CONSTANT_CURRENT_MODE_INDICATOR_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic ctrl_wr;
  assign ctrl_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I &&
    PADDR_I == CTRL_ADDR;
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held");
  a_ready_answer: assert property (
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O) else $error("no ready");
  a_err_qualified: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  a_reset_quiet: assert property ($past(RESET_I) |->
    CONSTANT_CURRENT_MODE_INDICATOR_O && !RUNNING_O &&
    DRIVE_LEVEL_O == 12'h000) else $error("not idle after reset");
  a_start_cause: assert property ($rose(RUNNING_O) |->
    $past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("run without start");
  a_invalid_blocks: assert property (
    CONFIG_INVALID_O && !RUNNING_O |=> !RUNNING_O)
    else $error("invalid setup started");
  a_stop_dark: assert property ($fell(RUNNING_O) |->
    ##[0:2] DRIVE_LEVEL_O == 12'h000) else $error("lit after stop");
  a_dig_follow: assert property (EXTERNAL_DIGITAL_MODE_INDICATOR_O &&
    $fell(EXT_DIGITAL_I) |-> ##[1:3] !LIGHT_ON_O)
    else $error("light ignores input");
  c_start: cover property ($rose(RUNNING_O));
  c_refused: cover property (PSLVERR_O);
  c_light: cover property ($rose(LIGHT_ON_O));
endmodule // lps_monitor

bind lps_sequencer lps_monitor mon (.CLK_I, .RESET_I, .PSEL_I, .PENABLE_I,
  .PWRITE_I, .PADDR_I, .EXT_DIGITAL_I, .PREADY_O, .PSLVERR_O,
  .DRIVE_LEVEL_O, .LIGHT_ON_O, .RUNNING_O, .CONFIG_INVALID_O,
  .EXTERNAL_DIGITAL_MODE_INDICATOR_O, .CONSTANT_CURRENT_MODE_INDICATOR_O);

// ===== test/lps_source.sv
// external signal source feeding the digital and analog inputs
// assumes its outputs are sampled on the same clock
module lps_source (
  input wire logic clk_i,
  input wire logic level_i,
  input wire logic [11:0] code_i,
  input wire logic [8:0] limit_ma_i,
  output logic dig_o,
  output logic [11:0] ana_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cap;
  assign cap = 32'(limit_ma_i) * 32'h1000 / 32'h190;
  initial begin
    dig_o = 1'b0;
    ana_o = 12'h000;
  end
  always @(posedge clk_i) begin
    dig_o <= level_i;
    // source keeps its peak under the light's limit
    ana_o <= (32'(code_i) > cap) ? 12'(cap) : code_i;
  end
endmodule // lps_source

// ===== test/lps_sequencer_tb_top.sv
// self-checking bench: apb scenarios against the sequencer
// assumes lps_source drives the external inputs
module lps_sequencer_tb_top
  import lps_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic prdy, perr, e, light, run, inv, ind_dig, ind_const, ext_dig;
  logic lvl = 1'b0;
  logic [11:0] code = 12'h000, ext_ana, drv;
  logic [8:0] lim = 9'h190;
  int bad_count = 0, n_checks = 0;
  initial begin
    forever #2 clk = ~clk;
  end
  lps_sequencer dut (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .EXT_DIGITAL_I(ext_dig), .EXT_ANALOG_I(ext_ana),
    .PRDATA_O(prdata), .PREADY_O(prdy), .PSLVERR_O(perr),
    .DRIVE_LEVEL_O(drv), .LIGHT_ON_O(light), .RUNNING_O(run),
    .CONFIG_INVALID_O(inv), .EXTERNAL_DIGITAL_MODE_INDICATOR_O(ind_dig),
    .CONSTANT_CURRENT_MODE_INDICATOR_O(ind_const));
  lps_source src (.clk_i(clk), .level_i(lvl), .code_i(code),
    .limit_ma_i(lim), .dig_o(ext_dig), .ana_o(ext_ana));
  task automatic wrap_up;
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, g);
      bad_count++;
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      wrap_up();
    end
    q = prdata;
    e = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic x);
    xfer(1'b1, a, d);
    chk("slverr", {31'h0, x}, {31'h0, e});
  endtask
  task automatic settle(input logic [11:0] v, input logic l, input string nm);
    for (int n = 0; n < 20 && (drv !== v || light !== l); n++) @(posedge clk);
    chk(nm, {19'h0, l, v}, {19'h0, light, drv});
  endtask
  task automatic s_reset;
    xfer(1'b0, STATUS_ADDR, 32'h0);
    chk("status", 32'h0, q);
    chk("const ind", 32'h1, {31'h0, ind_const});
    wr(16'h0048, 32'h0, 1'b1);
  endtask
  task automatic s_const;
    wr(MAXCUR_ADDR, 32'h12c, 1'b0);
    wr(CURRENT_ADDR, 32'h64, 1'b0);
    wr(CTRL_ADDR, 32'h1, 1'b0);
    settle(12'h064, 1'b1, "const level");
    chk("running", 32'h1, {31'h0, run});
    wr(PERIOD_ADDR, 32'ha, 1'b1);
    wr(CURRENT_ADDR, 32'h32, 1'b0);
    settle(12'h032, 1'b1, "adjusted level");
    wr(CTRL_ADDR, 32'h2, 1'b0);
    settle(12'h000, 1'b0, "stopped level");
    chk("stopped", 32'h0, {31'h0, run});
  endtask
  task automatic s_extdig;
    wr(CTRL_ADDR, 32'h11, 1'b0);
    chk("dig ind", 32'h1, {31'h0, ind_dig});
    lvl <= 1'b1;
    for (int n = 0; n < 20 && light !== 1'b1; n++) @(posedge clk);
    chk("light on", 32'h1, {31'h0, light});
    lvl <= 1'b0;
    for (int n = 0; n < 20 && light !== 1'b0; n++) @(posedge clk);
    chk("light off", 32'h0, {31'h0, light});
    wr(CTRL_ADDR, 32'h12, 1'b0);
  endtask
  task automatic s_analog;
    code <= 12'h800;
    wr(CTRL_ADDR, 32'h21, 1'b0);
    settle(12'h0c8, 1'b1, "analog half");
    code <= 12'hfff;
    settle(12'h12c, 1'b1, "analog clipped");
    wr(CTRL_ADDR, 32'h22, 1'b0);
  endtask
  task automatic s_square;
    int pulses, hi, per, r1;
    logic pl;
    pulses = 0;
    hi = 0;
    per = 0;
    r1 = 0;
    pl = 1'b0;
    // mode first: start only looks at the mode already stored
    wr(CTRL_ADDR, 32'h30, 1'b0);
    wr(SDELAY_ADDR, 32'h0, 1'b0);
    wr(PERIOD_ADDR, 32'ha, 1'b0);
    wr(PULSES_ADDR, 32'h3, 1'b0);
    wr(SEQS_ADDR, 32'h1, 1'b0);
    wr(ONTIME_ADDR, 32'h10, 1'b0);
    @(posedge clk);
    chk("invalid", 32'h1, {31'h0, inv});
    wr(CTRL_ADDR, 32'h31, 1'b0);
    chk("refused", 32'h0, {31'h0, run});
    wr(ONTIME_ADDR, 32'hf, 1'b0);
    @(posedge clk);
    chk("edge valid", 32'h0, {31'h0, inv});
    wr(ONTIME_ADDR, 32'h4, 1'b0);
    wr(CTRL_ADDR, 32'h31, 1'b0);
    // free divider cuts the first pulse; time the second and third
    for (int n = 0; n < 20000 && (run === 1'b1 || n < 4); n++) begin
      @(posedge clk);
      if (light === 1'b1 && !pl) begin
        pulses++;
        if (pulses == 2) r1 = n;
        else if (pulses == 3) per = n - r1;
      end
      if (light === 1'b1 && pulses == 2) hi++;
      pl = (light === 1'b1);
    end
    chk("ended", 32'h0, {31'h0, run});
    chk("pulses", 32'h3, 32'(pulses));
    chk("on cycles", 32'h3e8, 32'(hi));
    chk("period cycles", 32'h9c4, 32'(per));
    chk("end level", 32'h0, {20'h0, drv});
  endtask
  task automatic s_tables;
    wr(16'h1004, 32'h0000_c000, 1'b0);
    wr(16'h1008, 32'h0000_5000, 1'b0);
    xfer(1'b0, 16'h1004, 32'h0);
    chk("neg sample", 32'h0, q);
    xfer(1'b0, 16'h1008, 32'h0);
    chk("big sample", 32'h4000, q);
    wr(RISE_ADDR, 32'h2, 1'b0);
    wr(PLAT_ADDR, 32'h3, 1'b0);
    wr(FALL_ADDR, 32'h4, 1'b0);
    wr(CTRL_ADDR, 32'h130, 1'b0);
    xfer(1'b0, ONTIME_ADDR, 32'h0);
    chk("smooth on", 32'h9, q);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_reset();
    s_const();
    s_extdig();
    s_analog();
    s_square();
    s_tables();
    wrap_up();
  end
endmodule // lps_sequencer_tb_top
